// ### src/sfed_params.svh
// constants for the servo fault event detector
`ifndef SFED_PARAMS_SVH
`define SFED_PARAMS_SVH
`define SFED_ADDR_W        4
`define SFED_CODE_STOP     32'h64E20000
`define SFED_CODE_CMD      32'h74810000
`define SFED_CODE_COMPETE  32'h78010000
`define SFED_CODE_ABSENC   32'h78020000
`define SFED_CODE_STCHG    32'h84B10000
`define SFED_CODE_ILLEGAL  32'h84B20000
`define SFED_CODE_SYNC     32'h84B30000
`define SFED_CODE_WDOG     32'h84B50000
`define SFED_CODE_ESCINIT  32'h84B60000
`define SFED_CODE_VERIFY   32'h84B70000
`define SFED_CODE_SETTING  32'h84B80000
`define SFED_OFS_STATUS    4'h0
`define SFED_OFS_MASK      4'h1
`define SFED_OFS_CODE      4'h2
`define SFED_OFS_PEND      4'h3
`define SFED_OFS_WDOG_LIM  4'h4
`define SFED_OFS_SYNC_LIM  4'h5
`define SFED_OFS_WARN_LIM  4'h6
`define SFED_OFS_ROT_LIM   4'h7
`define SFED_OFS_CTRL      4'h8
`define SFED_N_EV          11
`define SFED_EV_STOP       0
`define SFED_EV_CMD        1
`define SFED_EV_COMPETE    2
`define SFED_EV_ABSENC     3
`define SFED_EV_STCHG      4
`define SFED_EV_ILLEGAL    5
`define SFED_EV_SYNC       6
`define SFED_EV_WDOG       7
`define SFED_EV_ESCINIT    8
`define SFED_EV_VERIFY     9
`define SFED_EV_SETTING    10
`define SFED_WDOG_LIM_RST  32'h000F4240
`define SFED_SYNC_LIM_RST  8'h03
`define SFED_WARN_LIM_RST  8'h03
`define SFED_ROT_LIM_RST   16'h0001
`define SFED_MODE_PP       8'h01
`define SFED_MODE_CSP      8'h08
`define SFED_MODE_CSV      8'h09
`define SFED_MODE_CST      8'h0A
`define SFED_MODE_HM       8'h06
`define SFED_NS_INIT       4'h1
`define SFED_NS_PREOP      4'h2
`define SFED_NS_SAFEOP     4'h4
`define SFED_NS_OP         4'h8
`endif

// ### src/sfed_pkg.sv
// types for the servo fault event detector
package sfed_pkg;
  // one network state-change request from the fieldbus side
  typedef struct packed {
    logic       valid;
    logic [3:0] cur;
    logic [3:0] req;
  } sfed_nsreq_t;
  // one object write from the host
  typedef struct packed {
    logic       mode_wr;
    logic [7:0] mode_val;
    logic       homing_start;
    logic [7:0] homing_method;
  } sfed_objwr_t;
endpackage : sfed_pkg

// ### src/sfed_top.sv
// servo fault event detector with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "sfed_params.svh"
// Behaviour
// - stop input raises immediate-stop event
// - remote, enabled, leaving operational: command error
// - local, test session, op or preop to init: command error
// - unsupported operation mode: command error
// - fully-closed with csv/cst: command error
// - homing with unsupported method: command error
// - consecutive data warnings reach count: error
// - trial run with preop or enable
// - power-up encoder rotation over limit
// - disallowed defined transition raises event
// - undefined transition code raises event
// - sync receive failures exceed limit
// - process data watchdog timeout
// - controller initialisation failure
// - slave verification failure
// - bad setting or unsupported state
module sfed_top (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESETN,
  input  wire logic [`SFED_ADDR_W-1:0] ADDR,
  input  wire logic [31:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [31:0]            RDATA,
  output logic                        IRQ,
  input  wire logic                   STOP_IN,
  input  wire logic                   REMOTE,
  input  wire logic                   SERVO_ON,
  input  wire logic                   FULLY_CLOSED,
  input  wire logic                   FREQUENCY_ANALYSIS_RUN,
  input  wire logic                   TEST_RUN,
  input  wire logic                   ENABLE_REQ,
  input  wire sfed_pkg::sfed_nsreq_t  NS_REQ,
  input  wire sfed_pkg::sfed_objwr_t  OBJ_WR,
  input  wire logic                   DATA_WARN,
  input  wire logic                   DATA_OK,
  input  wire logic                   SYNC_TICK,
  input  wire logic                   SYNC_RX,
  input  wire logic                   PDO_RX,
  input  wire logic                   POWER_UP_CHK,
  input  wire logic [15:0]            ENC_ROT,
  input  wire logic                   SLAVE_CTRL_INIT_FAIL,
  input  wire logic                   VERIFY_FAIL,
  input  wire logic                   SETTING_BAD,
  input  wire logic                   HOST_CLEAR,
  output logic      [31:0]            EVENT_CODE,
  output logic                        EVENT_PEND
);

  localparam int NE = `SFED_N_EV;

  // software registers
  logic [NE-1:0] status_reg;       // sticky event bits
  logic [NE-1:0] mask_reg;         // interrupt enables
  logic [31:0]   wdog_lim_reg;     // watchdog period in cycles
  logic [7:0]    sync_lim_reg;     // sync failure limit
  logic [7:0]    warn_lim_reg;     // data warning detection count
  logic [15:0]   rot_lim_reg;      // power-up rotation limit
  logic          ctrl_wd_en_reg;   // watchdog enable
  // detector state
  logic [31:0]   wdog_cnt_reg;     // cycles since last process data
  logic [7:0]    sync_cnt_reg;     // consecutive sync misses
  logic          sync_got_reg;     // data seen this sync cycle
  logic [7:0]    warn_cnt_reg;     // consecutive data warnings
  logic          stop_d_reg;       // stop input last cycle
  logic          pend_reg;         // first-event latch valid
  logic [31:0]   code_reg;         // first-event code
  logic [31:0]   rdata_reg;        // read answer
  logic          irq_reg;          // registered interrupt

  // bus decode
  wire wr_status = WR && (ADDR == `SFED_OFS_STATUS);
  wire wr_mask   = WR && (ADDR == `SFED_OFS_MASK);
  wire wr_pend   = WR && (ADDR == `SFED_OFS_PEND);
  wire wr_wlim   = WR && (ADDR == `SFED_OFS_WDOG_LIM);
  wire wr_slim   = WR && (ADDR == `SFED_OFS_SYNC_LIM);
  wire wr_clim   = WR && (ADDR == `SFED_OFS_WARN_LIM);
  wire wr_rlim   = WR && (ADDR == `SFED_OFS_ROT_LIM);
  wire wr_ctrl   = WR && (ADDR == `SFED_OFS_CTRL);

  // network state-change classification
  wire [3:0] cur = NS_REQ.cur;
  wire [3:0] req = NS_REQ.req;
  // only the four one-hot states are defined codes
  wire req_defined = (req == `SFED_NS_INIT) || (req == `SFED_NS_PREOP) ||
                     (req == `SFED_NS_SAFEOP) || (req == `SFED_NS_OP);
  // undefined code: zero, no bits set
  wire req_undef = NS_REQ.valid && (req == 4'h0);
  // unsupported state: any other non-one-hot pattern
  wire req_unsup = NS_REQ.valid && !req_defined && (req != 4'h0);
  // allowed steps: down to any lower state, or up by one
  wire step_ok = (req <= cur) || (req == {cur[2:0], 1'b0});
  wire req_bad_step = NS_REQ.valid && req_defined && !step_ok;

  // command error causes
  wire leave_op = NS_REQ.valid && (cur == `SFED_NS_OP) &&
                  (req != `SFED_NS_OP);
  wire c_remote = REMOTE && SERVO_ON && leave_op;
  wire to_init  = NS_REQ.valid && (req == `SFED_NS_INIT) &&
                  ((cur == `SFED_NS_OP) || (cur == `SFED_NS_PREOP));
  wire c_local  = !REMOTE && (FREQUENCY_ANALYSIS_RUN || TEST_RUN) &&
                  to_init;
  wire mode_known = (OBJ_WR.mode_val == `SFED_MODE_PP)  ||
                    (OBJ_WR.mode_val == `SFED_MODE_CSP) ||
                    (OBJ_WR.mode_val == `SFED_MODE_CSV) ||
                    (OBJ_WR.mode_val == `SFED_MODE_CST) ||
                    (OBJ_WR.mode_val == `SFED_MODE_HM);
  wire c_mode   = OBJ_WR.mode_wr && !mode_known;
  wire c_closed = OBJ_WR.mode_wr && FULLY_CLOSED &&
                  ((OBJ_WR.mode_val == `SFED_MODE_CSV) ||
                   (OBJ_WR.mode_val == `SFED_MODE_CST));
  wire [7:0] hm = OBJ_WR.homing_method;
  wire hm_ok = (hm == 8'h08) || (hm == 8'h0C) || (hm == 8'h13) ||
               (hm == 8'h14) || (hm == 8'h21) || (hm == 8'h22) ||
               (hm == 8'h23);
  wire c_home   = OBJ_WR.homing_start && !hm_ok;
  wire [7:0] warn_cnt_next = warn_cnt_reg + 8'h01;
  wire c_warn   = DATA_WARN && (warn_cnt_next >= warn_lim_reg);
  wire ev_cmd   = c_remote || c_local || c_mode || c_closed ||
                  c_home || c_warn;

  // trial-run competition
  wire to_preop = NS_REQ.valid && (cur == `SFED_NS_INIT) &&
                  (req == `SFED_NS_PREOP);
  wire ev_compete = FREQUENCY_ANALYSIS_RUN &&
                    (to_preop || ENABLE_REQ);

  // power-up rotation check
  wire ev_absenc = POWER_UP_CHK && (ENC_ROT > rot_lim_reg);

  // sync cycle miss counting
  wire got_now   = sync_got_reg || SYNC_RX;
  wire miss      = SYNC_TICK && !got_now;
  wire [7:0] sync_cnt_next = miss ? sync_cnt_reg + 8'h01 :
                             (SYNC_TICK ? 8'h00 : sync_cnt_reg);
  wire ev_sync   = miss && (sync_cnt_next > sync_lim_reg);

  // watchdog
  wire [31:0] wdog_cnt_next = PDO_RX ? 32'h0 :
    ((wdog_cnt_reg == 32'hFFFFFFFF) ? wdog_cnt_reg :
     wdog_cnt_reg + 32'h1);
  // at or past the limit: a count already beyond a lowered limit, or
  // one that ran on while disabled, must still trip and not saturate
  wire ev_wdog = ctrl_wd_en_reg && !PDO_RX &&
                 (wdog_cnt_reg >= wdog_lim_reg);

  // event vector
  wire [NE-1:0] ev;
  assign ev[`SFED_EV_STOP]    = STOP_IN && !stop_d_reg;
  assign ev[`SFED_EV_CMD]     = ev_cmd;
  assign ev[`SFED_EV_COMPETE] = ev_compete;
  assign ev[`SFED_EV_ABSENC]  = ev_absenc;
  assign ev[`SFED_EV_STCHG]   = req_bad_step;
  assign ev[`SFED_EV_ILLEGAL] = req_undef;
  assign ev[`SFED_EV_SYNC]    = ev_sync;
  assign ev[`SFED_EV_WDOG]    = ev_wdog;
  assign ev[`SFED_EV_ESCINIT] = SLAVE_CTRL_INIT_FAIL;
  assign ev[`SFED_EV_VERIFY]  = VERIFY_FAIL;
  assign ev[`SFED_EV_SETTING] = SETTING_BAD || req_unsup;

  // priority encode, lowest index first
  logic [31:0] ev_code;
  always_comb
  begin
    ev_code = 32'h0;
    for (int i = NE - 1; i >= 0; i--)
      if (ev[i])
        ev_code = code_of(i);
  end

  function automatic logic [31:0] code_of(input int i);
    logic [31:0] c;
    c = 32'h0;
    unique case (i)
      `SFED_EV_STOP:    c = `SFED_CODE_STOP;
      `SFED_EV_CMD:     c = `SFED_CODE_CMD;
      `SFED_EV_COMPETE: c = `SFED_CODE_COMPETE;
      `SFED_EV_ABSENC:  c = `SFED_CODE_ABSENC;
      `SFED_EV_STCHG:   c = `SFED_CODE_STCHG;
      `SFED_EV_ILLEGAL: c = `SFED_CODE_ILLEGAL;
      `SFED_EV_SYNC:    c = `SFED_CODE_SYNC;
      `SFED_EV_WDOG:    c = `SFED_CODE_WDOG;
      `SFED_EV_ESCINIT: c = `SFED_CODE_ESCINIT;
      `SFED_EV_VERIFY:  c = `SFED_CODE_VERIFY;
      default:          c = `SFED_CODE_SETTING;
    endcase
    return c;
  endfunction : code_of

  // first-event latch: a new event beats a clear in the same cycle
  wire clr_pend = HOST_CLEAR || (wr_pend && WDATA[0]);
  wire any_ev   = |ev;
  wire          pend_next = (pend_reg && !clr_pend) || any_ev;
  wire [31:0]   code_next = (any_ev && (!pend_reg || clr_pend)) ?
                            ev_code : code_reg;

  // sticky status: set wins over write-one-to-clear
  wire [NE-1:0] clr_bits    = wr_status ? WDATA[NE-1:0] : '0;
  wire [NE-1:0] status_next = (status_reg & ~clr_bits) | ev;
  wire          irq_next    = |(status_next & mask_reg);

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (ADDR)
      `SFED_OFS_STATUS:   rd_mux = {{(32-NE){1'b0}}, status_reg};
      `SFED_OFS_MASK:     rd_mux = {{(32-NE){1'b0}}, mask_reg};
      `SFED_OFS_CODE:     rd_mux = code_reg;
      `SFED_OFS_PEND:     rd_mux = {31'h0, pend_reg};
      `SFED_OFS_WDOG_LIM: rd_mux = wdog_lim_reg;
      `SFED_OFS_SYNC_LIM: rd_mux = {24'h0, sync_lim_reg};
      `SFED_OFS_WARN_LIM: rd_mux = {24'h0, warn_lim_reg};
      `SFED_OFS_ROT_LIM:  rd_mux = {16'h0, rot_lim_reg};
      `SFED_OFS_CTRL:     rd_mux = {31'h0, ctrl_wd_en_reg};
      default:            rd_mux = 32'h0;  // unmapped reads zero
    endcase
  end

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mask_reg       <= '0;
      wdog_lim_reg   <= `SFED_WDOG_LIM_RST;
      sync_lim_reg   <= `SFED_SYNC_LIM_RST;
      warn_lim_reg   <= `SFED_WARN_LIM_RST;
      rot_lim_reg    <= `SFED_ROT_LIM_RST;
      ctrl_wd_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_mask) mask_reg <= WDATA[NE-1:0];
      if (wr_wlim) wdog_lim_reg <= WDATA;
      if (wr_slim) sync_lim_reg <= WDATA[7:0];
      if (wr_clim) warn_lim_reg <= WDATA[7:0];
      if (wr_rlim) rot_lim_reg <= WDATA[15:0];
      if (wr_ctrl) ctrl_wd_en_reg <= WDATA[0];
    end
  end

  // detector counters
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wdog_cnt_reg <= 32'h0;
      sync_cnt_reg <= 8'h00;
      sync_got_reg <= 1'b0;
      warn_cnt_reg <= 8'h00;
      stop_d_reg   <= 1'b0;
    end
    else
    begin
      wdog_cnt_reg <= ev_wdog ? 32'h0 : wdog_cnt_next;
      sync_cnt_reg <= ev_sync ? 8'h00 : sync_cnt_next;
      sync_got_reg <= SYNC_TICK ? 1'b0 : got_now;
      // any good setting breaks the warning run
      if (c_warn || DATA_OK)
        warn_cnt_reg <= 8'h00;
      else if (DATA_WARN)
        warn_cnt_reg <= warn_cnt_next;
      stop_d_reg   <= STOP_IN;
    end
  end

  // event capture and outputs
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      status_reg <= '0;
      pend_reg   <= 1'b0;
      code_reg   <= 32'h0;
      rdata_reg  <= 32'h0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      pend_reg   <= pend_next;
      code_reg   <= code_next;
      rdata_reg  <= RD ? rd_mux : 32'h0;
      irq_reg    <= irq_next;
    end
  end

  assign RDATA      = rdata_reg;
  assign IRQ        = irq_reg;
  assign EVENT_CODE = code_reg;
  assign EVENT_PEND = pend_reg;

endmodule : sfed_top
`default_nettype wire

// ### testbench/sfed_top_monitor.sv
// checker on the fault event detector ports
`timescale 1ns/1ps
`default_nettype none
`include "sfed_params.svh"
module sfed_chk (
  input wire logic                    SYS_CLK,
  input wire logic                    RESETN,
  input wire logic [`SFED_ADDR_W-1:0] ADDR,
  input wire logic                    WR,
  input wire logic                    RD,
  input wire logic [31:0]             RDATA,
  input wire logic                    IRQ,
  input wire logic                    STOP_IN,
  input wire logic                    VERIFY_FAIL,
  input wire logic                    HOST_CLEAR,
  input wire logic [31:0]             EVENT_CODE,
  input wire logic                    EVENT_PEND
);
  // one domain, so clock and reset are given once
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  AST_RST_IDLE: assert property (
    !$past(RESETN) |-> !EVENT_PEND && !IRQ && EVENT_CODE == 32'h0)
    else $error("outputs not idle after reset");
  // stop is the lowest bit, so it always takes a free latch
  AST_STOP_CODE: assert property (
    !EVENT_PEND && $rose(STOP_IN) |=> EVENT_PEND
    && EVENT_CODE == `SFED_CODE_STOP)
    else $error("stop code not latched");
  AST_VERIFY_PEND: assert property (
    VERIFY_FAIL |=> EVENT_PEND)
    else $error("verify failure left no pending flag");
  AST_HOLD: assert property (
    EVENT_PEND && !HOST_CLEAR && !WR |=> EVENT_PEND && $stable(EVENT_CODE))
    else $error("latched code moved while pending");
  AST_FALL: assert property (
    $fell(EVENT_PEND) |-> $past(HOST_CLEAR) || $past(WR))
    else $error("pending dropped without a clear");
  AST_CODE_RD: assert property (
    RD && ADDR == `SFED_OFS_CODE |=> RDATA == $past(EVENT_CODE))
    else $error("code read wrong");
  AST_PEND_RD: assert property (
    RD && ADDR == `SFED_OFS_PEND |=> RDATA == {31'h0, $past(EVENT_PEND)})
    else $error("pending read wrong");
  AST_RD_IDLE: assert property (
    !RD |=> RDATA == 32'h0)
    else $error("read data outside its cycle");
endmodule : sfed_chk
bind sfed_top sfed_chk u_chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR(WR), .RD(RD),
  .RDATA(RDATA), .IRQ(IRQ), .STOP_IN(STOP_IN), .VERIFY_FAIL(VERIFY_FAIL),
  .HOST_CLEAR(HOST_CLEAR), .EVENT_CODE(EVENT_CODE),
  .EVENT_PEND(EVENT_PEND));
`default_nettype wire

// ### testbench/sfed_host_model.sv
// host controller model: state requests and object writes
`timescale 1ns/1ps
`default_nettype none
module sfed_host (
  input  wire logic                  clk,
  output var  sfed_pkg::sfed_nsreq_t ns_req,
  output var  sfed_pkg::sfed_objwr_t obj_wr
);
  // nothing requested at start
  initial ns_req = '0;
  initial obj_wr = '0;
  // fields flipped after the request so stale values never look valid
  task automatic ns(input logic [3:0] cur, input logic [3:0] req);
    ns_req <= '{1'b1, cur, req};
    @(posedge clk);
    ns_req <= '{1'b0, ~cur, ~req};
    @(posedge clk);
  endtask : ns
  // one mode write or homing start
  task automatic obj(input logic mw, input logic [7:0] mv,
                     input logic hs, input logic [7:0] hm);
    obj_wr <= '{mw, mv, hs, hm};
    @(posedge clk);
    obj_wr <= '{1'b0, ~mv, 1'b0, ~hm};
    @(posedge clk);
  endtask : obj
endmodule : sfed_host
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the fault event detector
`timescale 1ns/1ps
`default_nettype none
`include "sfed_params.svh"
module tb_top;
  logic                    clk   = 1'b0; // 4 ns period
  logic                    rst_n = 1'b0;
  logic [`SFED_ADDR_W-1:0] addr  = '0;
  logic [31:0]             wdata = '0;
  logic                    wr    = 1'b0;
  logic                    rd    = 1'b0;
  logic [11:0]             pv    = '0;   // one-cycle causes
  logic [4:0]              lv    = '0;   // remote,on,closed,fa,test
  logic [15:0]             rot   = '0;   // encoder rotation sample
  logic [31:0]             rdata;
  logic [31:0]             code;
  logic                    irq;
  logic                    pend;
  sfed_pkg::sfed_nsreq_t   nsr;
  sfed_pkg::sfed_objwr_t   obw;
  int                      miscompares = 0;
  int                      n_checks    = 0;
  int                      cyc         = 0;
  // expected code per status bit
  logic [31:0] cd [11] = '{`SFED_CODE_STOP, `SFED_CODE_CMD,
    `SFED_CODE_COMPETE, `SFED_CODE_ABSENC, `SFED_CODE_STCHG,
    `SFED_CODE_ILLEGAL, `SFED_CODE_SYNC, `SFED_CODE_WDOG,
    `SFED_CODE_ESCINIT, `SFED_CODE_VERIFY, `SFED_CODE_SETTING};
  logic [7:0]  hm [7] = '{8'h08, 8'h0C, 8'h13, 8'h14, 8'h21, 8'h22, 8'h23};
  logic [7:0]  md [5] = '{`SFED_MODE_PP, `SFED_MODE_HM, `SFED_MODE_CSP,
    `SFED_MODE_CSV, `SFED_MODE_CST};
  always #2 clk = ~clk;
  sfed_host host (.clk(clk), .ns_req(nsr), .obj_wr(obw));
  sfed_top dut (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .STOP_IN(pv[0]),
    .REMOTE(lv[0]), .SERVO_ON(lv[1]), .FULLY_CLOSED(lv[2]),
    .FREQUENCY_ANALYSIS_RUN(lv[3]), .TEST_RUN(lv[4]), .ENABLE_REQ(pv[9]),
    .NS_REQ(nsr), .OBJ_WR(obw), .DATA_WARN(pv[1]), .DATA_OK(pv[2]),
    .SYNC_TICK(pv[3]), .SYNC_RX(pv[4]), .PDO_RX(pv[10]),
    .POWER_UP_CHK(pv[5]), .ENC_ROT(rot), .SLAVE_CTRL_INIT_FAIL(pv[6]),
    .VERIFY_FAIL(pv[7]), .SETTING_BAD(pv[8]), .HOST_CLEAR(pv[11]),
    .EVENT_CODE(code), .EVENT_PEND(pend));
  // compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // extra edge at the end so strobes never retrigger in one step
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask : rd_reg
  task pulse(input logic [11:0] m);
    pv <= m;
    @(posedge clk);
    pv <= '0;
    @(posedge clk);
  endtask : pulse
  // one event on bit b, then cleared
  task ev(input int b);
    rd_reg(`SFED_OFS_STATUS, 32'h1 << b);
    rd_reg(`SFED_OFS_CODE, cd[b]);
    chk(code, cd[b]);
    chk({30'h0, pend, irq}, 32'h3);
    wr_reg(`SFED_OFS_STATUS, 32'h1 << b);
    wr_reg(`SFED_OFS_PEND, 32'h1);
    chk({30'h0, pend, irq}, 32'h0);
  endtask : ev
  task quiet;
    chk({30'h0, pend, irq}, 32'h0);
  endtask : quiet
  // defaults, unmapped place, then all events unmasked
  task t_regs;
    rd_reg(`SFED_OFS_SYNC_LIM, 32'h3);
    rd_reg(`SFED_OFS_WARN_LIM, 32'h3);
    rd_reg(`SFED_OFS_ROT_LIM, 32'h1);
    rd_reg(`SFED_OFS_CTRL, 32'h0);
    rd_reg(`SFED_OFS_PEND, 32'h0);
    rd_reg(`SFED_OFS_WDOG_LIM, `SFED_WDOG_LIM_RST);
    rd_reg(`SFED_OFS_MASK, 32'h0);
    wr_reg(4'hF, 32'hFFFFFFFF);
    rd_reg(4'hF, 32'h0);
    wr_reg(`SFED_OFS_MASK, 32'h7FF);
    rd_reg(`SFED_OFS_MASK, 32'h7FF);
  endtask : t_regs
  task t_pins;
    pulse(12'h001);
    ev(`SFED_EV_STOP);
    pulse(12'h040);
    ev(`SFED_EV_ESCINIT);
    pulse(12'h080);
    ev(`SFED_EV_VERIFY);
    pulse(12'h100);
    ev(`SFED_EV_SETTING);
  endtask : t_pins
  task t_net;
    host.ns(`SFED_NS_INIT, `SFED_NS_OP);
    ev(`SFED_EV_STCHG);
    host.ns(`SFED_NS_OP, 4'h0);
    ev(`SFED_EV_ILLEGAL);
    host.ns(`SFED_NS_INIT, 4'h3);
    ev(`SFED_EV_SETTING);
    lv <= 5'h01;
    host.ns(`SFED_NS_OP, `SFED_NS_SAFEOP);
    quiet();
    lv <= 5'h03;
    host.ns(`SFED_NS_OP, `SFED_NS_SAFEOP);
    ev(`SFED_EV_CMD);
    lv <= 5'h10;
    host.ns(`SFED_NS_PREOP, `SFED_NS_INIT);
    ev(`SFED_EV_CMD);
    lv <= 5'h00;
  endtask : t_net
  task t_obj;
    foreach (md[i])
      host.obj(1'b1, md[i], 1'b0, 8'h00);
    foreach (hm[i])
      host.obj(1'b0, 8'h00, 1'b1, hm[i]);
    quiet();
    host.obj(1'b1, 8'h02, 1'b0, 8'h00);
    ev(`SFED_EV_CMD);
    lv <= 5'h04;
    host.obj(1'b1, `SFED_MODE_CSV, 1'b0, 8'h00);
    ev(`SFED_EV_CMD);
    host.obj(1'b1, `SFED_MODE_CST, 1'b0, 8'h00);
    ev(`SFED_EV_CMD);
    lv <= 5'h00;
    host.obj(1'b0, 8'h00, 1'b1, 8'h01);
    ev(`SFED_EV_CMD);
  endtask : t_obj
  // run counts: warnings, sync misses, process data gap
  task t_count;
    int n;
    pulse(12'h002);
    pulse(12'h004);
    pulse(12'h002);
    pulse(12'h002);
    quiet();
    pulse(12'h002);
    ev(`SFED_EV_CMD);
    pulse(12'h010);
    repeat (4) pulse(12'h008);
    quiet();
    pulse(12'h008);
    ev(`SFED_EV_SYNC);
    pulse(12'h400);
    wr_reg(`SFED_OFS_WDOG_LIM, 32'hA);
    wr_reg(`SFED_OFS_CTRL, 32'h1);
    repeat (4) pulse(12'h400);
    quiet();
    n = 0;
    while (pend !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n > 6 && n < 14}, 32'h1);
    wr_reg(`SFED_OFS_CTRL, 32'h0);
    ev(`SFED_EV_WDOG);
  endtask : t_count
  task t_misc;
    // enable request outside a trial run is harmless
    pulse(12'h200);
    quiet();
    lv <= 5'h08;
    pulse(12'h200);
    ev(`SFED_EV_COMPETE);
    host.ns(`SFED_NS_INIT, `SFED_NS_PREOP);
    ev(`SFED_EV_COMPETE);
    lv  <= 5'h00;
    rot <= 16'h0001;
    pulse(12'h020);
    quiet();
    rot <= 16'h0002;
    pulse(12'h020);
    ev(`SFED_EV_ABSENC);
  endtask : t_misc
  // lower bit wins a tie, later events keep the latch, mask gates irq
  task t_latch;
    pulse(12'h0C0);
    pulse(12'h001);
    rd_reg(`SFED_OFS_CODE, `SFED_CODE_ESCINIT);
    rd_reg(`SFED_OFS_STATUS, 32'h301);
    wr_reg(`SFED_OFS_MASK, 32'h0);
    wr_reg(`SFED_OFS_STATUS, 32'h301);
    pulse(12'h800);
    quiet();
    pulse(12'h080);
    chk({30'h0, pend, irq}, 32'h2);
    wr_reg(`SFED_OFS_MASK, 32'h7FF);
    ev(`SFED_EV_VERIFY);
  endtask : t_latch
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pins();
    t_net();
    t_obj();
    t_count();
    t_misc();
    t_latch();
    results();
  end
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      results();
    end
  end
endmodule : tb_top
`default_nettype wire
